// File: rtl/rate_check_pkg.sv
// Constants and carriers for the channel rate select and VCO frequency check.
// Assumes a single 20 MHz clock and register access through a byte port.
`default_nettype none
package rate_check_pkg;
   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_RATE_SELECT = 8'h2F;
   localparam logic [7:0] ADDR_G0_COUNT_LOW = 8'h60;
   localparam logic [7:0] ADDR_G0_COUNT_HIGH = 8'h61;
   localparam logic [7:0] ADDR_G1_COUNT_LOW = 8'h62;
   localparam logic [7:0] ADDR_G1_COUNT_HIGH = 8'h63;
   localparam logic [7:0] ADDR_TOLERANCE = 8'h64;
   localparam logic [7:0] ADDR_CHANNEL_SELECT = 8'hFF;

   // Field positions
   localparam int RATE_LSB = 6;
   localparam int SUBRATE_LSB = 4;
   localparam int MANUAL_BIT = 7;
   localparam int TOL_G0_LSB = 4;
   localparam int TOL_G1_LSB = 0;
   localparam int CHSEL_CHANNEL_EN_BIT = 2;
   localparam int CHSEL_BROADCAST_BIT = 3;

   // Reset values
   localparam logic [7:0] RATE_SELECT_RESET = 8'h00;
   localparam logic [7:0] COUNT_REG_RESET = 8'h00;
   localparam logic [7:0] TOLERANCE_RESET = 8'hCD;
   localparam logic [7:0] CHANNEL_SELECT_RESET = 8'h00;
   localparam logic [7:0] READ_INVALID = 8'h00;

   // ---------------------------------------------------------------
   // Frequency check arithmetic
   // ---------------------------------------------------------------
   localparam int COUNT_W = 15;
   localparam int TOL_W = 4;
   localparam int REF_PERIODS = 1024;
   localparam longint REF_CLOCK_HZ = 25000000;
   localparam longint VCO_PRESCALE = 32;
   localparam longint VCO_MIN_KHZ = 8500000;
   localparam longint VCO_MAX_KHZ = 11300000;
   localparam longint G0_DEFAULT_RATE_KBPS = 1250000;
   localparam longint G0_DEFAULT_DIVIDE = 8;
   localparam longint G1_DEFAULT_RATE_KBPS = 10312500;
   localparam longint G1_DEFAULT_DIVIDE = 1;
   localparam longint KHZ = 1000;

   localparam longint COUNT_DEN = VCO_PRESCALE * REF_CLOCK_HZ / KHZ;
   localparam logic [COUNT_W-1:0] G0_DEFAULT_COUNT = COUNT_W'(
      (G0_DEFAULT_RATE_KBPS * G0_DEFAULT_DIVIDE * REF_PERIODS
      + COUNT_DEN / 2) / COUNT_DEN);
   localparam logic [COUNT_W-1:0] G1_DEFAULT_COUNT = COUNT_W'(
      (G1_DEFAULT_RATE_KBPS * G1_DEFAULT_DIVIDE * REF_PERIODS
      + COUNT_DEN / 2) / COUNT_DEN);
   localparam logic [COUNT_W-1:0] VCO_MIN_COUNT = COUNT_W'(
      (VCO_MIN_KHZ * REF_PERIODS + COUNT_DEN - 1) / COUNT_DEN);
   localparam logic [COUNT_W-1:0] VCO_MAX_COUNT = COUNT_W'(
      (VCO_MAX_KHZ * REF_PERIODS) / COUNT_DEN);

   // Divider codes: 0 = /1, 1 = /2, 2 = /4, 3 = /8
   localparam logic [1:0] DIV_CODE_8 = 2'h3;
   localparam logic [3:0] DIV1_M = 4'h1;
   localparam logic [3:0] DIV2_M = 4'h2;
   localparam logic [3:0] DIV4_M = 4'h4;
   localparam logic [3:0] DIV8_M = 4'h8;

   // Search candidate index: {divider code, group 0 first}
   localparam logic [2:0] CAND_FIRST = 3'h7;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_s;

   typedef struct packed {
      logic locked;
      logic searching;
      logic group;
      logic [1:0] div_code;
      logic range_error;
   } lock_status_s;
endpackage : rate_check_pkg
`default_nettype wire

// File: rtl/divide_ratio_table.sv
// Lookup of enabled VCO divide ratios per group from rate and subrate.
// Purely combinational; mask bit n enables divider code n.
`default_nettype none
module divide_ratio_table
(
   input wire logic [1:0] rate_in,
   input wire logic [1:0] subrate_in,
   output logic [3:0] group0_mask_out,
   output logic [3:0] group1_mask_out
);
   always_comb
   begin
      case ({rate_in, subrate_in})
         4'h0: group0_mask_out = rate_check_pkg::DIV8_M;
         4'h1, 4'h2, 4'h3: group0_mask_out = rate_check_pkg::DIV1_M
            | rate_check_pkg::DIV2_M | rate_check_pkg::DIV4_M;
         4'h4: group0_mask_out = rate_check_pkg::DIV2_M
            | rate_check_pkg::DIV4_M;
         4'h5: group0_mask_out = rate_check_pkg::DIV1_M
            | rate_check_pkg::DIV4_M;
         4'h6: group0_mask_out = rate_check_pkg::DIV1_M
            | rate_check_pkg::DIV2_M | rate_check_pkg::DIV4_M
            | rate_check_pkg::DIV8_M;
         4'hA: group0_mask_out = rate_check_pkg::DIV2_M;
         4'hB: group0_mask_out = rate_check_pkg::DIV2_M
            | rate_check_pkg::DIV4_M;
         4'hF: group0_mask_out = rate_check_pkg::DIV8_M;
         default: group0_mask_out = rate_check_pkg::DIV1_M;
      endcase
   end

   always_comb
   begin
      case ({rate_in, subrate_in})
         4'h0, 4'h1, 4'hF: group1_mask_out = rate_check_pkg::DIV1_M;
         default: group1_mask_out = group0_mask_out;
      endcase
   end
endmodule : divide_ratio_table
`default_nettype wire

// File: rtl/vco_freq_checker.sv
// Counts VCO/32 ticks over a window of reference ticks and compares
// the result with a target count and tolerance.
// Assumes both tick inputs are single-cycle pulses synchronous to clk_in.
`default_nettype none
module vco_freq_checker
#(
   parameter int REF_PERIODS = rate_check_pkg::REF_PERIODS
)
(
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic start_in,
   input wire logic ref_tick_in,
   input wire logic vco_tick_in,
   input wire logic [rate_check_pkg::COUNT_W-1:0] target_in,
   input wire logic [rate_check_pkg::TOL_W-1:0] tolerance_in,
   output logic done_out,
   output logic match_out
);
   localparam int REF_W = $clog2(REF_PERIODS + 1);
   localparam logic [REF_W-1:0] REF_LAST = REF_W'(REF_PERIODS - 1);
   localparam logic [rate_check_pkg::COUNT_W-1:0] COUNT_SAT = '1;

   logic busy_q, busy_d;
   logic done_q, done_d;
   logic match_q, match_d;
   logic [REF_W-1:0] ref_cnt_q, ref_cnt_d;
   logic [rate_check_pkg::COUNT_W-1:0] vco_cnt_q, vco_cnt_d;
   logic [rate_check_pkg::COUNT_W-1:0] final_cnt;
   logic [rate_check_pkg::COUNT_W-1:0] diff;

   always_comb
   begin
      busy_d = busy_q;
      done_d = 1'b0;
      match_d = match_q;
      ref_cnt_d = ref_cnt_q;
      vco_cnt_d = vco_cnt_q;
      final_cnt = vco_cnt_q;
      diff = '0;
      if (start_in)
      begin
         busy_d = 1'b1;
         ref_cnt_d = '0;
         vco_cnt_d = '0;
      end
      else if (busy_q)
      begin
         // Saturate so a runaway input cannot wrap into a false match
         if (vco_tick_in && vco_cnt_q != COUNT_SAT)
         begin
            vco_cnt_d = vco_cnt_q + 1'b1;
            final_cnt = vco_cnt_d;
         end
         if (ref_tick_in)
         begin
            ref_cnt_d = ref_cnt_q + 1'b1;
            if (ref_cnt_q == REF_LAST)
            begin
               diff = (final_cnt > target_in) ? final_cnt - target_in
                  : target_in - final_cnt;
               busy_d = 1'b0;
               done_d = 1'b1;
               match_d = (diff <= rate_check_pkg::COUNT_W'(tolerance_in));
            end
         end
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         busy_q <= 1'b0;
         done_q <= 1'b0;
         match_q <= 1'b0;
         ref_cnt_q <= '0;
         vco_cnt_q <= '0;
      end
      else
      begin
         busy_q <= busy_d;
         done_q <= done_d;
         match_q <= match_d;
         ref_cnt_q <= ref_cnt_d;
         vco_cnt_q <= vco_cnt_d;
      end
   end

   assign done_out = done_q;
   assign match_out = match_q;
endmodule : vco_freq_checker
`default_nettype wire

// File: rtl/channel_rate_control.sv
// Channel rate/subrate selection, VCO frequency targets and lock search.
// Assumes the byte register port is driven by an SMBus target front end
// and that tick inputs are synchronous single-cycle pulses.
`default_nettype none
module channel_rate_control
#(
   parameter logic [1:0] CHANNEL_ID = 2'h0,
   parameter int REF_PERIODS = rate_check_pkg::REF_PERIODS
)
(
   input wire logic clk_in,
   input wire logic srst_in,
   input wire rate_check_pkg::reg_req_s req_in,
   input wire logic signal_detect_in,
   input wire logic ref_tick_in,
   input wire logic vco_tick_in,
   output logic [7:0] rd_data_out,
   output logic rd_valid_out,
   output rate_check_pkg::lock_status_s status_out
);
   typedef enum logic [3:0]
   {
      ST_IDLE = 4'b0001,
      ST_SELECT = 4'b0010,
      ST_MEASURE = 4'b0100,
      ST_LOCKED = 4'b1000
   } search_state_e;

   // ---------------------------------------------------------------
   // Register file
   // ---------------------------------------------------------------
   logic [7:0] chsel_q, chsel_d;
   logic [7:0] rate_sel_q, rate_sel_d;
   logic [7:0] g0_low_q, g0_low_d;
   logic [7:0] g0_high_q, g0_high_d;
   logic [7:0] g1_low_q, g1_low_d;
   logic [7:0] g1_high_q, g1_high_d;
   logic [7:0] tol_q, tol_d;
   logic [7:0] rd_data_q, rd_data_d;
   logic rd_valid_q;
   logic ch_wr, ch_rd, cfg_changed;

   always_comb
   begin
      // Broadcast writes reach every channel; reads only the named one
      ch_wr = req_in.wr && chsel_q[rate_check_pkg::CHSEL_CHANNEL_EN_BIT]
         && (chsel_q[rate_check_pkg::CHSEL_BROADCAST_BIT]
         || chsel_q[1:0] == CHANNEL_ID);
      ch_rd = req_in.rd && chsel_q[rate_check_pkg::CHSEL_CHANNEL_EN_BIT]
         && chsel_q[1:0] == CHANNEL_ID;
      chsel_d = chsel_q;
      rate_sel_d = rate_sel_q;
      g0_low_d = g0_low_q;
      g0_high_d = g0_high_q;
      g1_low_d = g1_low_q;
      g1_high_d = g1_high_q;
      tol_d = tol_q;
      cfg_changed = 1'b0;
      if (req_in.wr && req_in.addr == rate_check_pkg::ADDR_CHANNEL_SELECT)
         chsel_d = req_in.wdata;
      else if (ch_wr)
      begin
         cfg_changed = 1'b1;
         case (req_in.addr)
            rate_check_pkg::ADDR_RATE_SELECT: rate_sel_d = req_in.wdata;
            rate_check_pkg::ADDR_G0_COUNT_LOW: g0_low_d = req_in.wdata;
            rate_check_pkg::ADDR_G0_COUNT_HIGH: g0_high_d = req_in.wdata;
            rate_check_pkg::ADDR_G1_COUNT_LOW: g1_low_d = req_in.wdata;
            rate_check_pkg::ADDR_G1_COUNT_HIGH: g1_high_d = req_in.wdata;
            rate_check_pkg::ADDR_TOLERANCE: tol_d = req_in.wdata;
            default: cfg_changed = 1'b0;
         endcase
      end
      // The select register has no readback; unmapped reads give zero
      rd_data_d = rate_check_pkg::READ_INVALID;
      if (ch_rd && req_in.addr != rate_check_pkg::ADDR_CHANNEL_SELECT)
      begin
         case (req_in.addr)
            rate_check_pkg::ADDR_RATE_SELECT: rd_data_d = rate_sel_q;
            rate_check_pkg::ADDR_G0_COUNT_LOW: rd_data_d = g0_low_q;
            rate_check_pkg::ADDR_G0_COUNT_HIGH: rd_data_d = g0_high_q;
            rate_check_pkg::ADDR_G1_COUNT_LOW: rd_data_d = g1_low_q;
            rate_check_pkg::ADDR_G1_COUNT_HIGH: rd_data_d = g1_high_q;
            rate_check_pkg::ADDR_TOLERANCE: rd_data_d = tol_q;
            default: rd_data_d = rate_check_pkg::READ_INVALID;
         endcase
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         chsel_q <= rate_check_pkg::CHANNEL_SELECT_RESET;
         rate_sel_q <= rate_check_pkg::RATE_SELECT_RESET;
         g0_low_q <= rate_check_pkg::COUNT_REG_RESET;
         g0_high_q <= rate_check_pkg::COUNT_REG_RESET;
         g1_low_q <= rate_check_pkg::COUNT_REG_RESET;
         g1_high_q <= rate_check_pkg::COUNT_REG_RESET;
         tol_q <= rate_check_pkg::TOLERANCE_RESET;
         rd_data_q <= rate_check_pkg::READ_INVALID;
         rd_valid_q <= 1'b0;
      end
      else
      begin
         chsel_q <= chsel_d;
         rate_sel_q <= rate_sel_d;
         g0_low_q <= g0_low_d;
         g0_high_q <= g0_high_d;
         g1_low_q <= g1_low_d;
         g1_high_q <= g1_high_d;
         tol_q <= tol_d;
         rd_data_q <= rd_data_d;
         rd_valid_q <= req_in.rd;
      end
   end

   // ---------------------------------------------------------------
   // Active targets and enabled ratios
   // ---------------------------------------------------------------
   logic group0_manual_enable, group1_manual_enable;
   logic [rate_check_pkg::COUNT_W-1:0] group0_target_count;
   logic [rate_check_pkg::COUNT_W-1:0] group1_target_count;
   logic [rate_check_pkg::TOL_W-1:0] group0_tolerance, group1_tolerance;
   logic [rate_check_pkg::COUNT_W-1:0] target;
   logic [rate_check_pkg::TOL_W-1:0] tolerance;
   logic [3:0] g0_mask, g1_mask;
   logic cand_enabled, target_in_range;

   always_comb
   begin
      group0_manual_enable = g0_high_q[rate_check_pkg::MANUAL_BIT];
      group1_manual_enable = g1_high_q[rate_check_pkg::MANUAL_BIT];
      group0_target_count = group0_manual_enable
         ? {g0_high_q[6:0], g0_low_q}
         : rate_check_pkg::G0_DEFAULT_COUNT;
      group1_target_count = group1_manual_enable
         ? {g1_high_q[6:0], g1_low_q}
         : rate_check_pkg::G1_DEFAULT_COUNT;
      group0_tolerance =
         tol_q[rate_check_pkg::TOL_G0_LSB +: rate_check_pkg::TOL_W];
      group1_tolerance =
         tol_q[rate_check_pkg::TOL_G1_LSB +: rate_check_pkg::TOL_W];
   end

   divide_ratio_table u_ratio_table
   (
      .rate_in(rate_sel_q[rate_check_pkg::RATE_LSB +: 2]),
      .subrate_in(rate_sel_q[rate_check_pkg::SUBRATE_LSB +: 2]),
      .group0_mask_out(g0_mask),
      .group1_mask_out(g1_mask)
   );

   // ---------------------------------------------------------------
   // Lock search
   // ---------------------------------------------------------------
   search_state_e state_q, state_d;
   logic [2:0] cand_q, cand_d;
   logic start_q, start_d;
   logic range_err_q, range_err_d;
   rate_check_pkg::lock_status_s status_q, status_d;
   logic check_done, check_match;
   logic cand_group;
   logic [1:0] cand_div;

   always_comb
   begin
      // Group 0 is tried before group 1 at each divide ratio
      cand_div = cand_q[2:1];
      cand_group = ~cand_q[0];
      target = cand_group ? group1_target_count : group0_target_count;
      tolerance = cand_group ? group1_tolerance : group0_tolerance;
      cand_enabled = cand_group ? g1_mask[cand_div] : g0_mask[cand_div];
      target_in_range = target >= rate_check_pkg::VCO_MIN_COUNT
         && target <= rate_check_pkg::VCO_MAX_COUNT;
   end

   always_comb
   begin
      state_d = state_q;
      cand_d = cand_q;
      start_d = 1'b0;
      range_err_d = range_err_q;
      case (state_q)
         ST_IDLE:
         begin
            cand_d = rate_check_pkg::CAND_FIRST;
            if (signal_detect_in)
               state_d = ST_SELECT;
         end
         ST_SELECT:
         begin
            // Out-of-range targets are skipped and reported
            if (cand_enabled && target_in_range)
            begin
               start_d = 1'b1;
               range_err_d = 1'b0;
               state_d = ST_MEASURE;
            end
            else
            begin
               if (cand_enabled)
                  range_err_d = 1'b1;
               cand_d = cand_q - 1'b1;
            end
         end
         ST_MEASURE:
         begin
            if (check_done)
            begin
               if (check_match)
                  state_d = ST_LOCKED;
               else
               begin
                  cand_d = cand_q - 1'b1;
                  state_d = ST_SELECT;
               end
            end
         end
         ST_LOCKED:
         begin
         end
         default:
            state_d = ST_IDLE;
      endcase
      // Losing the signal or a retune restarts the search
      if (!signal_detect_in || cfg_changed)
         state_d = ST_IDLE;
      // Registered from next-state values so the port timing is unchanged
      status_d.locked = state_d == ST_LOCKED;
      status_d.searching = state_d == ST_SELECT || state_d == ST_MEASURE;
      status_d.group = ~cand_d[0];
      status_d.div_code = cand_d[2:1];
      status_d.range_error = range_err_d;
   end

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         state_q <= ST_IDLE;
         cand_q <= rate_check_pkg::CAND_FIRST;
         start_q <= 1'b0;
         range_err_q <= 1'b0;
         status_q <= '{locked: 1'b0, searching: 1'b0, group: 1'b0,
            div_code: rate_check_pkg::DIV_CODE_8, range_error: 1'b0};
      end
      else
      begin
         state_q <= state_d;
         cand_q <= cand_d;
         start_q <= start_d;
         range_err_q <= range_err_d;
         status_q <= status_d;
      end
   end

   vco_freq_checker
   #(
      .REF_PERIODS(REF_PERIODS)
   )
   u_checker
   (
      .clk_in(clk_in),
      .srst_in(srst_in),
      .start_in(start_q),
      .ref_tick_in(ref_tick_in),
      .vco_tick_in(vco_tick_in),
      .target_in(target),
      .tolerance_in(tolerance),
      .done_out(check_done),
      .match_out(check_match)
   );

   // ---------------------------------------------------------------
   // Ports
   // ---------------------------------------------------------------
   // Every port is a flop so nothing ripples out of the search logic
   assign rd_data_out = rd_data_q;
   assign rd_valid_out = rd_valid_q;
   assign status_out = status_q;
endmodule : channel_rate_control
`default_nettype wire

// File: testbench/rate_ctrl_chk.sv
// Port checker for the channel rate control block.
// Assumes only the top module's ports; bound at the foot of this file.
`default_nettype none
module rate_ctrl_chk
#(
   parameter logic [1:0] CHANNEL_ID = 2'h0,
   parameter int REF_PERIODS = 1024
)
(
   input wire logic clk_in,
   input wire logic srst_in,
   input wire rate_check_pkg::reg_req_s req_in,
   input wire logic signal_detect_in,
   input wire logic ref_tick_in,
   input wire logic vco_tick_in,
   input wire logic [7:0] rd_data_out,
   input wire logic rd_valid_out,
   input wire rate_check_pkg::lock_status_s status_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] chsel_q, chsel_d, rate_q, rate_d;
   logic rd_ok, wr_ok, wr_chan;

   default clocking @(posedge clk_in); endclocking
   default disable iff (srst_in);

   // Shadow of the select and rate registers as seen from the port
   always_comb
   begin
      rd_ok = chsel_q[2] && chsel_q[1:0] == CHANNEL_ID;
      wr_ok = chsel_q[2] && (chsel_q[1:0] == CHANNEL_ID || chsel_q[3]);
      wr_chan = req_in.wr && wr_ok && (req_in.addr == 8'h2F
         || (req_in.addr >= 8'h60 && req_in.addr <= 8'h64));
      chsel_d = (req_in.wr && req_in.addr == 8'hFF) ? req_in.wdata : chsel_q;
      rate_d = (wr_chan && req_in.addr == 8'h2F) ? req_in.wdata : rate_q;
   end

   always_ff @(posedge clk_in)
   begin
      chsel_q <= srst_in ? 8'h00 : chsel_d;
      rate_q <= srst_in ? 8'h00 : rate_d;
   end

   chk_read_answer: assert property (req_in.rd |=> rd_valid_out)
      else $error("read got no answer");
   chk_quiet_port: assert property (!req_in.rd |=>
      !rd_valid_out && rd_data_out == 8'h00)
      else $error("data or valid without a read");
   chk_select_hidden: assert property (req_in.rd &&
      req_in.addr == 8'hFF |=> rd_data_out == 8'h00)
      else $error("select register read back");
   chk_unrouted_zero: assert property (req_in.rd && !rd_ok
      |=> rd_data_out == 8'h00)
      else $error("unrouted read returned data");
   chk_rate_readback: assert property (req_in.rd && rd_ok &&
      req_in.addr == 8'h2F |=> rd_data_out[7:4] == $past(rate_q[7:4]))
      else $error("rate field read back wrong");
   chk_loss_unlocks: assert property (!signal_detect_in |=>
      !status_out.locked && !status_out.searching)
      else $error("active without signal");
   chk_write_unlocks: assert property (wr_chan |=> !status_out.locked)
      else $error("lock kept over a register write");
   chk_lock_holds: assert property (status_out.locked &&
      signal_detect_in && !wr_chan |=> status_out.locked)
      else $error("lock dropped without cause");
   chk_lock_measured: assert property ($rose(status_out.locked)
      |-> $past(status_out.searching))
      else $error("lock without a search");
   chk_lock_steady: assert property (status_out.locked [*2] |->
      $stable({status_out.group, status_out.div_code}))
      else $error("candidate moved while locked");

   cov_lock_g0: cover property (status_out.locked && !status_out.group);
   cov_lock_g1: cover property (status_out.locked && status_out.group);
   cov_range: cover property (status_out.range_error);
endmodule : rate_ctrl_chk

bind channel_rate_control rate_ctrl_chk #(.CHANNEL_ID(CHANNEL_ID),
   .REF_PERIODS(REF_PERIODS)) i_rate_ctrl_chk (.clk_in, .srst_in, .req_in,
   .signal_detect_in, .ref_tick_in, .vco_tick_in, .rd_data_out,
   .rd_valid_out, .status_out);
`default_nettype wire

// File: testbench/line_tick_source.sv
// Line side model: reference tick source and recovered VCO/32 ticks.
// Assumes the VCO tracks the line, one tick a cycle while signal is up.
`default_nettype none
module line_tick_source
#(
   parameter int REF_DIV = 11
)
(
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic signal_in,
   output logic ref_tick_out,
   output logic vco_tick_out
);
   timeunit 1ns;
   timeprecision 1ps;
   int phase_q;

   // Reference runs free at a fixed ratio whatever the line does
   always_ff @(posedge clk_in)
   begin
      phase_q <= (srst_in || phase_q == REF_DIV - 1) ? 0 : phase_q + 1;
      ref_tick_out <= !srst_in && phase_q == REF_DIV - 1;
      vco_tick_out <= !srst_in && signal_in;
   end
endmodule : line_tick_source
`default_nettype wire

// File: testbench/channel_rate_control_bench.sv
// Self-checking bench for the channel rate control block.
// Assumes the checker is bound and the line model sets the tick ratio.
`default_nettype none
module channel_rate_control_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in = 1'b0, srst_in = 1'b1, sig = 1'b0;
   rate_check_pkg::reg_req_s req = '0;
   rate_check_pkg::lock_status_s st;
   logic [7:0] rdata;
   logic rvalid, ref_tick, vco_tick;
   logic [3:0] m0, m1;
   logic [14:0] c0, c1;
   logic [39:0] prog;
   logic [7:0] addrs [6] = '{8'h2F, 8'h60, 8'h61, 8'h62, 8'h63, 8'h64};
   logic [7:0] rsts [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hCD};
   int bad_count = 0, n_compared = 0, n;

   channel_rate_control i_channel_rate_control (.clk_in, .srst_in,
      .req_in(req), .signal_detect_in(sig), .ref_tick_in(ref_tick),
      .vco_tick_in(vco_tick), .rd_data_out(rdata), .rd_valid_out(rvalid),
      .status_out(st));
   line_tick_source i_line_tick_source (.clk_in, .srst_in, .signal_in(sig),
      .ref_tick_out(ref_tick), .vco_tick_out(vco_tick));

   initial forever #25 clk_in = ~clk_in;

   task automatic check(string what, logic [7:0] exp, logic [7:0] got);
      n_compared++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value %s: expected %h, seen %h", what, exp, got);
      end
   endtask : check

   task automatic reg_wr(logic [7:0] a, logic [7:0] d);
      @(posedge clk_in);
      #1 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk_in);
      #1 req.wr = 1'b0;
   endtask : reg_wr

   task automatic reg_rd(logic [7:0] a, logic [7:0] exp);
      @(posedge clk_in);
      #1 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk_in);
      #1 req.rd = 1'b0;
      check("read valid", 8'h01, {7'h00, rvalid});
      check($sformatf("register %h", a), exp, rdata);
   endtask : reg_rd

   // Bound covers two full measurement windows plus the skips
   task automatic wait_lock(logic grp, logic [1:0] div);
      for (int i = 0; i < 30000 && st.locked !== 1'b1; i++)
         @(posedge clk_in);
      #1;
      check("lock", {5'h01, grp, div}, {4'h0, st.locked, st.group,
         st.div_code});
   endtask : wait_lock

   task automatic set_sig(logic v);
      @(posedge clk_in);
      #1 sig = v;
   endtask : set_sig

   // Controller side: count rounded from VCO/32 over 1024 references
   function automatic logic [14:0] vco_count(longint khz);
      return 15'((khz * 1024 + 400000) / 800000);
   endfunction : vco_count

   function automatic logic [3:0] tol_of(logic [14:0] c);
      return (c / 1000 > 15) ? 4'hF : 4'(c / 1000);
   endfunction : tol_of

   // First candidate the search settles on: /8 down to /1, group 0 first
   function automatic logic [2:0] first_cand(logic [3:0] g0, logic [3:0] g1);
      for (int d = 3; d >= 0; d--)
      begin
         if (g0[d])
            return {1'b0, 2'(d)};
         if (g1[d])
            return {1'b1, 2'(d)};
      end
      return 3'h0;
   endfunction : first_cand

   task automatic wrap_up;
      $display("compared %0d, mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : wrap_up

   // Six measurement windows of about 11k cycles fit well inside this
   initial
   begin
      #5_000_000;
      bad_count++;
      wrap_up();
   end

   initial
   begin
      repeat (20) @(posedge clk_in);
      #1 srst_in = 1'b0;
      reg_rd(8'h2F, 8'h00);
      reg_wr(8'hFF, 8'h04);
      for (int i = 0; i < 6; i++)
         reg_rd(addrs[i], rsts[i]);
      reg_rd(8'hFF, 8'h00);
      reg_rd(8'h30, 8'h00);
      reg_wr(8'h2F, 8'hC0);
      reg_rd(8'h2F, 8'hC0);
      reg_wr(8'hFF, 8'h05);
      reg_wr(8'h2F, 8'h40);
      reg_rd(8'h2F, 8'h00);
      reg_wr(8'hFF, 8'h0D);
      reg_wr(8'h2F, 8'h50);
      reg_wr(8'hFF, 8'h04);
      reg_rd(8'h2F, 8'h50);
      reg_wr(8'h2F, 8'h00);
      $display("test registers done");
      c0 = vco_count(64'd1250000 * 8);
      c1 = vco_count(64'd10312500);
      prog = {tol_of(c0), tol_of(c1), 1'b1, c1[14:8], c1[7:0], 1'b1,
         c0[14:8], c0[7:0]};
      for (int i = 0; i < 5; i++)
         reg_wr(8'h60 + 8'(i), prog[8*i +: 8]);
      for (int i = 0; i < 5; i++)
         reg_rd(8'h60 + 8'(i), 8'(40'hCDB390B200 >> (8 * i)));
      $display("test programming done");
      // The search shows the first enabled candidate for each setting
      set_sig(1'b1);
      for (int p = 0; p < 2; p++)
      begin
         // Group 0 out of range on the second pass exposes group 1
         if (p == 1)
            reg_wr(8'h61, 8'h80);
         for (int i = 0; i < 16; i++)
         begin
            m0 = p ? 4'h0 : 4'(64'h8111_6211_1F56_7778 >> 4 * i);
            m1 = 4'(64'h1111_6211_1F56_7711 >> 4 * i);
            reg_wr(8'h2F, 8'(i << 4));
            repeat (12) @(posedge clk_in);
            #1 check("first ratio", {5'h01, first_cand(m0, m1)}, {4'h0,
               st.searching, st.group, st.div_code});
         end
      end
      reg_wr(8'h2F, 8'h00);
      $display("test ratios done");
      // Targets sit near 1024 x 11 ticks; tolerance absorbs tick phase
      reg_wr(8'h62, 8'hFB);
      reg_wr(8'h63, 8'hAB);
      reg_wr(8'h60, 8'hFB);
      reg_wr(8'h61, 8'hAB);
      set_sig(1'b1);
      wait_lock(1'b0, 2'h3);
      reg_wr(8'h60, 8'h23);
      repeat (3) @(posedge clk_in);
      #1 check("search", 8'h0B, {4'h0, st.searching, st.group,
         st.div_code});
      wait_lock(1'b1, 2'h0);
      $display("test lock done");
      set_sig(1'b0);
      reg_wr(8'h60, 8'hFB);
      reg_wr(8'h61, 8'h2B);
      check("unlocked", 8'h00, {7'h00, st.locked});
      set_sig(1'b1);
      wait_lock(1'b1, 2'h0);
      $display("test override done");
      set_sig(1'b0);
      reg_wr(8'h61, 8'h80);
      set_sig(1'b1);
      n = 0;
      while (st.range_error !== 1'b1 && n < 40)
      begin
         @(posedge clk_in);
         #1 n++;
      end
      check("range", 8'h01, {7'h00, st.range_error});
      wait_lock(1'b1, 2'h0);
      $display("test range done");
      wrap_up();
   end
endmodule : channel_rate_control_bench
`default_nettype wire
